// File: src/mmdec_pkg.sv
// Package with register map, field layout and address windows of the memory map decoder.
`default_nettype none
package mmdec_pkg;
    // Register offsets (printed offsets are not word multiples, so they are indices).
    localparam logic [11:0] IDX_MAP_CTRL   = 12'hFD0;
    localparam logic [11:0] IDX_MAP_KEY    = 12'hFD1;
    localparam logic [11:0] IDX_MAP_SHADOW = 12'hFD2;
    localparam logic [11:0] IDX_MAP_STATUS = 12'hFD3;
    localparam logic [11:0] IDX_SERIAL_MD  = 12'hFD4;
    // Fields and reset values.
    localparam int          BOOT_SEL_BIT   = 4;
    localparam logic [7:0]  CTRL_RESET     = 8'h40;
    localparam logic [7:0]  CTRL_WMASK     = 8'hFF;
    localparam logic [7:0]  MAP_KEY_VALUE  = 8'hD5;
    localparam int          STATUS_USED    = 3;
    // Code space windows.
    localparam logic [16:0] CODE_FLASH_LO  = 17'h10000;
    localparam logic [16:0] CODE_FLASH_HI  = 17'h1FFFF;
    localparam logic [16:0] CODE_BOOT_LO   = 17'h11000;
    localparam logic [16:0] CODE_BOOT_HI   = 17'h117FF;
    // Data space windows.
    localparam logic [16:0] SFR1_LO        = 17'h00000;
    localparam logic [16:0] SFR1_HI        = 17'h0003F;
    localparam logic [16:0] SFR2_LO        = 17'h00F00;
    localparam logic [16:0] SFR2_HI        = 17'h00FFF;
    localparam logic [16:0] SFR3_LO        = 17'h00E40;
    localparam logic [16:0] SFR3_HI        = 17'h00EFF;
    localparam logic [16:0] RAM_LO         = 17'h00040;
    localparam logic [16:0] RAM_HI         = 17'h00C3F;
    localparam logic [16:0] DATA_FLASH_LO  = 17'h01000;
    localparam logic [16:0] DATA_FLASH_HI  = 17'h0FFFF;
    localparam logic [16:0] DATA_BOOT_LO   = 17'h01000;
    localparam logic [16:0] DATA_BOOT_HI   = 17'h017FF;
    localparam int          BOOT_MAP_BITS  = 11;
    localparam logic [7:0]  SWI_OPCODE     = 8'hFF;
    // Decoded target of an access.
    typedef enum logic [2:0] {
        MMDEC_NONE, MMDEC_SFR, MMDEC_RAM, MMDEC_FLASH, MMDEC_BOOT, MMDEC_SWI
    } mmdec_tgt_t;
endpackage
`default_nettype wire

// File: src/mmdec_map_if.sv
// Interface carrying the active map setting from the register file to the decoders.
`default_nettype none
interface mmdec_map_if;
    logic       boot_map;
    logic       serial_mode;
    modport src (output boot_map, output serial_mode);
    modport dst (input boot_map, input serial_mode);
endinterface
`default_nettype wire

// File: src/mmdec_space.sv
// One address space decoder: the code or data window map.
`default_nettype none
module mmdec_space
    import mmdec_pkg::*;
#(
    parameter bit IS_CODE     = 1'b1,
    parameter bit FLASH_BIG   = 1'b1
) (
    // Clock and reset.
    input  wire logic        i_clk,
    input  wire logic        i_arst_n,
    // Map setting.
    mmdec_map_if.dst         map,
    // Access.
    input  wire logic        i_req,
    input  wire logic [16:0] i_addr,
    output mmdec_tgt_t       o_tgt,
    output logic [16:0]      o_offs
);
    mmdec_tgt_t  tgt_nxt;
    logic [16:0] offs_nxt;

    function automatic logic inr(input logic [16:0] a, input logic [16:0] lo, input logic [16:0] hi);
        inr = (a >= lo) && (a <= hi);
    endfunction

    always_comb begin
        tgt_nxt  = MMDEC_NONE;
        offs_nxt = 17'h00000;
        if (!i_req) begin
            tgt_nxt = MMDEC_NONE;
        end else if (IS_CODE) begin
            if (map.boot_map && (inr(i_addr, CODE_BOOT_LO, CODE_BOOT_HI) || map.serial_mode)
                && i_addr >= CODE_FLASH_LO) begin
                tgt_nxt  = MMDEC_BOOT;
                offs_nxt = map.serial_mode ? i_addr - CODE_FLASH_LO : i_addr - CODE_BOOT_LO;
            end else if (inr(i_addr, CODE_BOOT_LO, CODE_BOOT_HI) && !FLASH_BIG) begin
                tgt_nxt = MMDEC_SWI;
            end else if (inr(i_addr, CODE_FLASH_LO, CODE_FLASH_HI)) begin
                tgt_nxt  = MMDEC_FLASH;
                offs_nxt = i_addr - CODE_FLASH_LO;
            end
        end else begin
            if (inr(i_addr, SFR1_LO, SFR1_HI) || inr(i_addr, SFR2_LO, SFR2_HI)
                || inr(i_addr, SFR3_LO, SFR3_HI)) begin
                tgt_nxt  = MMDEC_SFR;
                offs_nxt = i_addr;
            end else if (inr(i_addr, RAM_LO, RAM_HI)) begin
                tgt_nxt  = MMDEC_RAM;
                offs_nxt = i_addr - RAM_LO;
            end else if (map.boot_map && inr(i_addr, DATA_BOOT_LO, DATA_BOOT_HI)) begin
                tgt_nxt  = MMDEC_BOOT;
                offs_nxt = i_addr - DATA_BOOT_LO;
            end else if (inr(i_addr, DATA_FLASH_LO, DATA_FLASH_HI)) begin
                tgt_nxt  = MMDEC_FLASH;
                offs_nxt = i_addr - DATA_FLASH_LO;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_tgt  <= MMDEC_NONE;
            o_offs <= 17'h00000;
        end else begin
            o_tgt  <= tgt_nxt;
            o_offs <= offs_nxt;
        end
    end

    a_boot_off_unmapped: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_req && !map.boot_map) |=> (o_tgt != MMDEC_BOOT))
        else $error("Boot ROM decoded while unmapped.");
    a_boot_window_hit: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_req && map.boot_map && !IS_CODE && inr(i_addr, DATA_BOOT_LO, DATA_BOOT_HI)) |=> (o_tgt == MMDEC_BOOT))
        else $error("Boot ROM lost priority in data space.");
endmodule
`default_nettype wire

// File: src/mmdec_top.sv
// Top of the memory map decoder: APB register file, key-gated shadow and two space decoders.
`default_nettype none
// Behaviour
// - After reset the boot ROM is mapped in neither code nor data space.
// - With the boot select bit set and the key written, boot ROM sits at 0x11000-0x117FF code and 0x01000-0x017FF data.
// - Outside serial programming mode only the lowest 2 KB of the boot ROM are reachable.
// - An unmapped boot region fetch returns Flash or a software-interrupt opcode per Flash size.
// - Control writes land in a front buffer and reach the active shadow only on key 0xD5.
// - A shadow readback register returns the setting in force, not the buffered one.
// - Flash is decoded at code addresses 0x10000-0x1FFFF.
// - Flash is decoded at data addresses 0x01000-0x0FFFF.
// - SFRs are decoded at data 0x00000-0x0003F, 0x00F00-0x00FFF and 0x00E40-0x00EFF.
// - RAM is decoded at data addresses 0x00040-0x00C3F.
// - RAM contents are not initialised at reset.
// - Bits 7 to 3 of the map status register read as zero.
// - Map status bit 0 shows the boot select in force, not the pending value; bits 2 and 1 read as zero.
module mmdec_top
    import mmdec_pkg::*;
#(
    parameter bit FLASH_BIG = 1'b1
) (
    // Clock and reset.
    input  wire logic        i_clk,
    input  wire logic        i_arst_n,
    // APB slave.
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [15:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Code fetch port.
    input  wire logic        i_code_req,
    input  wire logic [16:0] i_code_addr,
    output mmdec_tgt_t       o_code_tgt,
    output logic [16:0]      o_code_offs,
    output logic [7:0]       o_swi_opcode,
    // Data access port.
    input  wire logic        i_data_req,
    input  wire logic [16:0] i_data_addr,
    output mmdec_tgt_t       o_data_tgt,
    output logic [16:0]      o_data_offs,
    // Map setting in force.
    output logic             o_boot_mapped
);
    logic [7:0]  ctrl_r;
    logic [7:0]  ctrl_nxt;
    logic [7:0]  shadow_r;
    logic [7:0]  shadow_nxt;
    logic        serial_r;
    logic        serial_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic        err_r;
    logic        err_nxt;
    logic        ack_r;
    logic        ack_nxt;
    logic        acc;
    logic        wr;
    logic [11:0] idx;
    logic        hit;

    mmdec_map_if map_bus ();

    // One wait state lets read data and error settle in a flip-flop before pready is shown.
    assign acc       = i_psel && i_penable;
    assign wr        = acc && i_pwrite && ack_r;
    assign idx       = i_paddr[13:2];
    assign o_pready  = ack_r;
    assign o_prdata  = rdata_r;
    assign o_pslverr = err_r;

    always_comb begin
        hit = (i_paddr[1:0] == 2'b00) && (idx == IDX_MAP_CTRL || idx == IDX_MAP_KEY
              || idx == IDX_MAP_SHADOW || idx == IDX_MAP_STATUS || idx == IDX_SERIAL_MD);
    end

    always_comb begin
        ctrl_nxt   = ctrl_r;
        shadow_nxt = shadow_r;
        serial_nxt = serial_r;
        if (wr && hit && idx == IDX_MAP_CTRL) begin
            ctrl_nxt = i_pwdata[7:0] & CTRL_WMASK;
        end
        if (wr && hit && idx == IDX_MAP_KEY && i_pwdata[7:0] == MAP_KEY_VALUE) begin
            shadow_nxt = ctrl_r;
        end
        if (wr && hit && idx == IDX_SERIAL_MD) begin
            serial_nxt = i_pwdata[0];
        end
    end

    always_comb begin
        rdata_nxt = 32'h00000000;
        err_nxt   = 1'b0;
        ack_nxt   = acc && !ack_r;
        if (acc && !ack_r && !hit) begin
            err_nxt = 1'b1;
        end else if (acc && !ack_r && !i_pwrite) begin
            case (idx)
                IDX_MAP_CTRL:   rdata_nxt = {24'h000000, ctrl_r};
                IDX_MAP_KEY:    rdata_nxt = 32'h00000000;
                IDX_MAP_SHADOW: rdata_nxt = {24'h000000, shadow_r};
                IDX_MAP_STATUS: rdata_nxt = {29'h00000000, 2'b00, shadow_r[BOOT_SEL_BIT]};
                IDX_SERIAL_MD:  rdata_nxt = {31'h00000000, serial_r};
                default:        rdata_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_r   <= CTRL_RESET;
            shadow_r <= CTRL_RESET;
            serial_r <= 1'b0;
            rdata_r  <= 32'h00000000;
            err_r    <= 1'b0;
            ack_r    <= 1'b0;
        end else begin
            ack_r    <= ack_nxt;
            ctrl_r   <= ctrl_nxt;
            shadow_r <= shadow_nxt;
            serial_r <= serial_nxt;
            rdata_r  <= rdata_nxt;
            err_r    <= err_nxt;
        end
    end

    // Read data is registered in the first access cycle and stands while pready is high.
    // RAM storage itself is outside this block and is left uninitialised.
    assign map_bus.boot_map    = shadow_r[BOOT_SEL_BIT];
    assign map_bus.serial_mode = serial_r;
    assign o_boot_mapped       = shadow_r[BOOT_SEL_BIT];
    assign o_swi_opcode        = SWI_OPCODE;

    mmdec_space #(
        .IS_CODE   (1'b1),
        .FLASH_BIG (FLASH_BIG)
    ) u_code (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .map      (map_bus.dst),
        .i_req    (i_code_req),
        .i_addr   (i_code_addr),
        .o_tgt    (o_code_tgt),
        .o_offs   (o_code_offs)
    );

    mmdec_space #(
        .IS_CODE   (1'b0),
        .FLASH_BIG (FLASH_BIG)
    ) u_data (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .map      (map_bus.dst),
        .i_req    (i_data_req),
        .i_addr   (i_data_addr),
        .o_tgt    (o_data_tgt),
        .o_offs   (o_data_offs)
    );

    a_key_commits: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (wr && idx == IDX_MAP_KEY && i_pwdata[7:0] == MAP_KEY_VALUE && i_paddr[1:0] == 2'b00)
        |=> (shadow_r == $past(ctrl_r)))
        else $error("Key did not commit the front buffer.");
    a_bad_key_holds: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (wr && idx == IDX_MAP_KEY && i_pwdata[7:0] != MAP_KEY_VALUE) |=> $stable(shadow_r))
        else $error("Wrong key changed the active setting.");
    a_ctrl_no_effect: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (wr && idx == IDX_MAP_CTRL) |=> $stable(shadow_r))
        else $error("Control write took effect without key.");
    a_status_upper_zero: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (acc && !i_pwrite && idx == IDX_MAP_STATUS && hit) |=> (o_prdata[7:STATUS_USED] == 5'h00))
        else $error("Status upper bits not zero.");
    a_status_in_force: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (acc && !ack_r && !i_pwrite && idx == IDX_MAP_STATUS && hit) |=> (o_prdata[0] == shadow_r[BOOT_SEL_BIT]))
        else $error("Status bit differs from active setting.");
    a_shadow_readback: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (acc && !ack_r && !i_pwrite && idx == IDX_MAP_SHADOW && hit) |=> (o_prdata[7:0] == $past(shadow_r)))
        else $error("Shadow readback wrong.");
    a_code_flash_map: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_code_req && !shadow_r[BOOT_SEL_BIT] && i_code_addr >= CODE_FLASH_LO && FLASH_BIG)
        |=> (o_code_tgt == MMDEC_FLASH && o_code_offs == $past(i_code_addr) - CODE_FLASH_LO))
        else $error("Code flash decode wrong.");
    a_ram_decode: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_data_req && i_data_addr >= RAM_LO && i_data_addr <= RAM_HI) |=> (o_data_tgt == MMDEC_RAM))
        else $error("RAM decode wrong.");
    a_sfr_decode: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_data_req && i_data_addr >= SFR2_LO && i_data_addr <= SFR2_HI) |=> (o_data_tgt == MMDEC_SFR))
        else $error("SFR decode wrong.");
    a_data_flash: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_data_req && i_data_addr > DATA_BOOT_HI && i_data_addr <= DATA_FLASH_HI
         && !(i_data_addr >= SFR3_LO && i_data_addr <= SFR2_HI))
        |=> (o_data_tgt == MMDEC_FLASH))
        else $error("Data flash decode wrong.");
    a_boot_code_map: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_code_req && shadow_r[BOOT_SEL_BIT] && i_code_addr >= CODE_BOOT_LO && i_code_addr <= CODE_BOOT_HI)
        |=> (o_code_tgt == MMDEC_BOOT && o_code_offs < 17'h00800))
        else $error("Boot ROM code decode wrong.");
endmodule
`default_nettype wire

// File: tb/mmdec_cpu_model.sv
// Partner model of the CPU core that issues code fetches and data accesses.
`default_nettype none
module mmdec_cpu_model
    import mmdec_pkg::*;
(
    // Clock.
    input  wire logic        i_clk,
    // Requests.
    output logic             o_code_req,
    output logic [16:0]      o_code_addr,
    output logic             o_data_req,
    output logic [16:0]      o_data_addr,
    // Decode results.
    input  wire mmdec_tgt_t  i_code_tgt,
    input  wire logic [16:0] i_code_offs,
    input  wire mmdec_tgt_t  i_data_tgt,
    input  wire logic [16:0] i_data_offs
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        o_code_req  = 1'b0;
        o_code_addr = 17'h00000;
        o_data_req  = 1'b0;
        o_data_addr = 17'h00000;
    end

    // One access; the caller's address is issued with its request, reserved ones included, then both address buses get its inverse.
    task automatic access(input logic c, input logic [16:0] a, output mmdec_tgt_t t, output logic [16:0] o);
        @(posedge i_clk);
        if (c) begin
            o_code_req  <= 1'b1;
            o_code_addr <= a;
        end else begin
            o_data_req  <= 1'b1;
            o_data_addr <= a;
        end
        @(posedge i_clk);
        o_code_req  <= 1'b0;
        o_data_req  <= 1'b0;
        o_code_addr <= ~a;
        o_data_addr <= ~a;
        @(negedge i_clk);
        t = c ? i_code_tgt : i_data_tgt;
        o = c ? i_code_offs : i_data_offs;
    endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Self-checking testbench of the memory map decoder.
`default_nettype none
module testbench
    import mmdec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        i_clk, i_arst_n, psel, penable, pwrite, pready, pslverr;
    logic        code_req, data_req, boot_mapped;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [16:0] code_addr, data_addr, code_offs, data_offs, last_offs;
    logic [7:0]  swi;
    mmdec_tgt_t  code_tgt, data_tgt;
    int          fail_count = 0;
    int          check_count = 0;

    mmdec_top #(.FLASH_BIG(1'b1)) dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_code_req(code_req), .i_code_addr(code_addr),
        .o_code_tgt(code_tgt), .o_code_offs(code_offs), .o_swi_opcode(swi), .i_data_req(data_req),
        .i_data_addr(data_addr), .o_data_tgt(data_tgt), .o_data_offs(data_offs), .o_boot_mapped(boot_mapped));

    mmdec_cpu_model cpu (.i_clk(i_clk), .o_code_req(code_req), .o_code_addr(code_addr),
        .o_data_req(data_req), .o_data_addr(data_addr), .i_code_tgt(code_tgt), .i_code_offs(code_offs),
        .i_data_tgt(data_tgt), .i_data_offs(data_offs));

    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d,
                       output logic [31:0] rd, output logic er);
        @(posedge i_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h000000, d};
        @(posedge i_clk);
        penable <= 1'b1;
        @(posedge i_clk);
        while (pready !== 1'b1) @(posedge i_clk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] idx, input logic [7:0] e, input string nm);
        logic [31:0] r;
        logic        er;
        apb(1'b0, idx, 8'h00, r, er);
        chk(nm, {24'h000000, e}, r);
        chk("pslverr", 32'h0, {31'h0, er});
    endtask

    task automatic wr(input logic [11:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic        er;
        apb(1'b1, idx, d, r, er);
        chk("pslverr", 32'h0, {31'h0, er});
    endtask

    task automatic dec(input logic c, input logic [16:0] a, input mmdec_tgt_t e);
        mmdec_tgt_t t;
        cpu.access(c, a, t, last_offs);
        chk(c ? "code target" : "data target", {29'h0, e}, {29'h0, t});
    endtask

    initial begin
        #200000;
        fail_count++;
        tally_and_finish();
    end

    initial begin
        logic [31:0] r;
        logic        er;
        i_arst_n = 1'b0;
        {psel, penable, pwrite} = 3'b000;
        paddr = 16'h0000;
        pwdata = 32'h0;
        repeat (6) @(posedge i_clk);
        i_arst_n <= 1'b1;
        rd(IDX_MAP_CTRL, CTRL_RESET, "control");
        rd(IDX_MAP_SHADOW, CTRL_RESET, "shadow");
        rd(IDX_MAP_STATUS, 8'h00, "status");
        chk("boot_mapped", 32'h0, {31'h0, boot_mapped});
        chk("swi opcode", 32'h000000FF, {24'h0, swi});
        dec(1'b1, 17'h10000, MMDEC_FLASH);
        dec(1'b1, 17'h1FFFF, MMDEC_FLASH);
        dec(1'b1, 17'h11000, MMDEC_FLASH);
        dec(1'b0, 17'h00000, MMDEC_SFR);
        dec(1'b0, 17'h0003F, MMDEC_SFR);
        dec(1'b0, 17'h00E40, MMDEC_SFR);
        dec(1'b0, 17'h00FFF, MMDEC_SFR);
        dec(1'b0, 17'h00040, MMDEC_RAM);
        dec(1'b0, 17'h00C3F, MMDEC_RAM);
        dec(1'b0, 17'h00C40, MMDEC_NONE);
        dec(1'b0, 17'h01000, MMDEC_FLASH);
        dec(1'b0, 17'h0FFFF, MMDEC_FLASH);
        wr(IDX_MAP_CTRL, 8'h50);
        rd(IDX_MAP_CTRL, 8'h50, "control");
        rd(IDX_MAP_SHADOW, 8'h40, "shadow");
        dec(1'b1, 17'h11000, MMDEC_FLASH);
        wr(IDX_MAP_KEY, 8'hD4);
        rd(IDX_MAP_STATUS, 8'h00, "status");
        rd(IDX_MAP_KEY, 8'h00, "key");
        wr(IDX_MAP_KEY, MAP_KEY_VALUE);
        rd(IDX_MAP_SHADOW, 8'h50, "shadow");
        rd(IDX_MAP_STATUS, 8'h01, "status");
        chk("boot_mapped", 32'h1, {31'h0, boot_mapped});
        dec(1'b1, 17'h117FF, MMDEC_BOOT);
        chk("boot offset", 32'h7FF, {15'h0, last_offs});
        dec(1'b1, 17'h11800, MMDEC_FLASH);
        dec(1'b0, 17'h01000, MMDEC_BOOT);
        dec(1'b0, 17'h017FF, MMDEC_BOOT);
        dec(1'b0, 17'h01800, MMDEC_FLASH);
        dec(1'b0, 17'h00F00, MMDEC_SFR);
        apb(1'b0, 12'h100, 8'h00, r, er);
        chk("unmapped pslverr", 32'h1, {31'h0, er});
        wr(IDX_MAP_CTRL, CTRL_RESET);
        wr(IDX_MAP_KEY, MAP_KEY_VALUE);
        @(negedge i_clk);
        chk("boot_mapped", 32'h0, {31'h0, boot_mapped});
        dec(1'b0, 17'h01000, MMDEC_FLASH);
        tally_and_finish();
    end
endmodule
`default_nettype wire
